// >>> src/ctcr_regs.sv
`timescale 1ns/10ps
`default_nettype none
module ctcr_regs
    import ctcr_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_B_IN,
    input wire ctcr_req_t REQ_IN,
    output logic [7:0] RDATA_OUT,
    output ctcr_ctl_t CTL_OUT,
    output logic TIMING_CAL_PULSE_OUT
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] cfg0, next_cfg0;
    logic [7:0] back, next_back;
    logic [7:0] pat, next_pat;
    logic [7:0] vec, next_vec;
    logic [7:0] tcal, next_tcal;
    logic [7:0] rdata, next_rdata;
    logic [CTCR_PTR_W-1:0] ptr, next_ptr;
    logic [7:0] vec_mem [CTCR_VEC_DEPTH];
    logic [7:0] next_vec_mem [CTCR_VEC_DEPTH];
    ctcr_state_t state, next_state;
    logic [7:0] cnt, next_cnt;
    logic done, next_done;
    logic tpulse, next_tpulse;
    logic active, next_active;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit(input ctcr_req_t r, input logic [11:0] a);
        hit = r.addr == a;
    endfunction

    function automatic logic wr_hit(input ctcr_req_t r, input logic [11:0] a);
        wr_hit = r.wr && hit(r, a);
    endfunction

    function automatic logic rd_hit(input ctcr_req_t r, input logic [11:0] a);
        rd_hit = r.rd && hit(r, a);
    endfunction

    logic vec_en;
    logic vec_acc;
    logic vec_rise;
    logic trig;
    assign vec_en = cfg0[CTCR_VEC_EN_BIT];
    assign vec_acc = vec_en
        && (wr_hit(REQ_IN, CTCR_VEC_ADDR) || rd_hit(REQ_IN, CTCR_VEC_ADDR));
    // Enable lands now, so even a back-to-back access starts at the first entry
    assign vec_rise = wr_hit(REQ_IN, CTCR_CFG0_ADDR)
        && REQ_IN.wdata[CTCR_VEC_EN_BIT] && !vec_en;
    assign trig = wr_hit(REQ_IN, CTCR_CFG0_ADDR) && REQ_IN.wdata[CTCR_TRIG_BIT];

    // ------------------------------------------------------------
    // Calibration configuration
    // ------------------------------------------------------------
    always_comb begin
        next_cfg0 = cfg0;
        if (wr_hit(REQ_IN, CTCR_CFG0_ADDR)) begin
            next_cfg0 = REQ_IN.wdata;
            // Trigger acts as a strobe and never stays set
            next_cfg0[CTCR_TRIG_BIT] = 1'b0;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cfg0 <= CTCR_CFG0_RST;
        end else begin
            cfg0 <= next_cfg0;
        end
    end

    // ------------------------------------------------------------
    // Background control
    // ------------------------------------------------------------
    always_comb begin
        next_back = back;
        if (wr_hit(REQ_IN, CTCR_BACK_ADDR)) begin
            next_back = REQ_IN.wdata;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            back <= CTCR_BACK_RST;
        end else begin
            back <= next_back;
        end
    end

    // ------------------------------------------------------------
    // Pattern and over-range enables
    // ------------------------------------------------------------
    always_comb begin
        next_pat = pat;
        if (wr_hit(REQ_IN, CTCR_PAT_ADDR)) begin
            next_pat = REQ_IN.wdata & CTCR_PAT_MASK;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            pat <= CTCR_PAT_RST;
        end else begin
            pat <= next_pat;
        end
    end

    // ------------------------------------------------------------
    // Vector port holding register
    // ------------------------------------------------------------
    always_comb begin
        next_vec = vec;
        if (wr_hit(REQ_IN, CTCR_VEC_ADDR)) begin
            next_vec = REQ_IN.wdata;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            vec <= CTCR_VEC_RST;
        end else begin
            vec <= next_vec;
        end
    end

    // ------------------------------------------------------------
    // Timing calibration control
    // ------------------------------------------------------------
    always_comb begin
        next_tcal = tcal;
        if (wr_hit(REQ_IN, CTCR_TCAL_ADDR)) begin
            next_tcal = (REQ_IN.wdata & CTCR_TCAL_MASK) | CTCR_TCAL_RST;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            tcal <= CTCR_TCAL_RST;
        end else begin
            tcal <= next_tcal;
        end
    end

    // ------------------------------------------------------------
    // Vector sequence pointer
    // ------------------------------------------------------------
    always_comb begin
        next_ptr = ptr;
        if (vec_rise) begin
            next_ptr = CTCR_PTR_ZERO;
        end else if (vec_acc) begin
            next_ptr = ptr + CTCR_PTR_ONE;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ptr <= CTCR_PTR_ZERO;
        end else begin
            ptr <= next_ptr;
        end
    end

    // ------------------------------------------------------------
    // Calibration vector store
    // ------------------------------------------------------------
    for (genvar g = 0; g < CTCR_VEC_DEPTH; g++) begin : g_vec
        always_comb begin
            next_vec_mem[g] = vec_mem[g];
            if (vec_acc && REQ_IN.wr && ptr == CTCR_PTR_W'(g)) begin
                next_vec_mem[g] = REQ_IN.wdata;
            end
        end

        // Data only: no reset, contents undefined until loaded
        always_ff @(posedge MCLK_IN) begin
            vec_mem[g] <= next_vec_mem[g];
        end
    end

    // ------------------------------------------------------------
    // Calibration sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_done = done;
        next_tpulse = 1'b0;
        if (trig) begin
            next_state = CTCR_FG;
            next_cnt = CTCR_FG_CYCLES;
            next_tpulse = tcal[CTCR_TAUTO_BIT];
        end else begin
            case (state)
                CTCR_IDLE: begin
                    if (back[CTCR_RUN_BIT] && back[CTCR_BCK_BIT]) begin
                        next_state = CTCR_BG;
                        next_cnt = CTCR_BG_CYCLES;
                    end
                end
                CTCR_FG: begin
                    if (cnt == CTCR_CNT_ONE) begin
                        next_done = 1'b1;
                        next_state = CTCR_IDLE;
                    end
                    next_cnt = cnt - CTCR_CNT_ONE;
                end
                CTCR_BG: begin
                    if (cnt == CTCR_CNT_ONE) begin
                        next_done = 1'b1;
                        // Pass ends normally; run and background bits together decide on a new pass
                        if (back[CTCR_RUN_BIT] && back[CTCR_BCK_BIT]) begin
                            next_cnt = CTCR_BG_CYCLES;
                        end else begin
                            next_state = CTCR_IDLE;
                            next_cnt = CTCR_CNT_ZERO;
                        end
                    end else begin
                        next_cnt = cnt - CTCR_CNT_ONE;
                    end
                end
                default: begin
                    next_state = CTCR_IDLE;
                end
            endcase
        end
        next_active = next_state != CTCR_IDLE;
    end

    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state <= CTCR_IDLE;
            cnt <= CTCR_CNT_ZERO;
            done <= 1'b0;
            tpulse <= 1'b0;
            active <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            done <= next_done;
            tpulse <= next_tpulse;
            active <= next_active;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        if (REQ_IN.rd) begin
            if (hit(REQ_IN, CTCR_CFG0_ADDR)) begin
                next_rdata = cfg0;
            end else if (hit(REQ_IN, CTCR_BACK_ADDR)) begin
                next_rdata = back;
            end else if (hit(REQ_IN, CTCR_PAT_ADDR)) begin
                next_rdata = pat;
            end else if (hit(REQ_IN, CTCR_VEC_ADDR)) begin
                next_rdata = vec_en ? vec_mem[ptr] : vec;
            end else if (hit(REQ_IN, CTCR_STAT_ADDR)) begin
                next_rdata = CTCR_STAT_RSVD;
                next_rdata[CTCR_STOP_BIT] = state == CTCR_IDLE;
                next_rdata[CTCR_DONE_BIT] = done;
            end else if (hit(REQ_IN, CTCR_TCAL_ADDR)) begin
                next_rdata = tcal;
            end
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign RDATA_OUT = rdata;
    assign CTL_OUT = '{
        test_pattern_enable: pat[CTCR_PAT_BIT],
        overrange_enable: pat[CTCR_OVR_BIT],
        timing_auto: tcal[CTCR_TAUTO_BIT],
        calibration_active: active
    };
    assign TIMING_CAL_PULSE_OUT = tpulse;
endmodule
`default_nettype wire

// >>> inc/ctcr_pkg.sv
`default_nettype none
package ctcr_pkg;
    // Register offsets
    localparam logic [11:0] CTCR_CFG0_ADDR = 12'h050;
    localparam logic [11:0] CTCR_BACK_ADDR = 12'h057;
    localparam logic [11:0] CTCR_PAT_ADDR = 12'h058;
    localparam logic [11:0] CTCR_VEC_ADDR = 12'h05A;
    localparam logic [11:0] CTCR_STAT_ADDR = 12'h05B;
    localparam logic [11:0] CTCR_TCAL_ADDR = 12'h066;
    // Reset values and fixed reserved status bits
    localparam logic [7:0] CTCR_CFG0_RST = 8'h06;
    localparam logic [7:0] CTCR_BACK_RST = 8'h10;
    localparam logic [7:0] CTCR_PAT_RST = 8'h00;
    localparam logic [7:0] CTCR_VEC_RST = 8'h00;
    localparam logic [7:0] CTCR_TCAL_RST = 8'h02;
    localparam logic [7:0] CTCR_STAT_RSVD = 8'h08;
    // Field positions
    localparam int CTCR_VEC_EN_BIT = 4;
    localparam int CTCR_TRIG_BIT = 3;
    localparam int CTCR_RUN_BIT = 1;
    localparam int CTCR_BCK_BIT = 0;
    localparam int CTCR_PAT_BIT = 2;
    localparam int CTCR_OVR_BIT = 1;
    localparam int CTCR_STOP_BIT = 1;
    localparam int CTCR_DONE_BIT = 0;
    localparam int CTCR_TAUTO_BIT = 0;
    localparam logic [7:0] CTCR_PAT_MASK = 8'h06;
    localparam logic [7:0] CTCR_TCAL_MASK = 8'h01;
    // Calibration vector store and sequence timing
    localparam int CTCR_VEC_DEPTH = 16;
    localparam int CTCR_PTR_W = 4;
    localparam logic [CTCR_PTR_W-1:0] CTCR_PTR_ZERO = 4'h0;
    localparam logic [CTCR_PTR_W-1:0] CTCR_PTR_ONE = 4'h1;
    localparam logic [7:0] CTCR_FG_CYCLES = 8'h40;
    localparam logic [7:0] CTCR_BG_CYCLES = 8'h20;
    localparam logic [7:0] CTCR_CNT_ZERO = 8'h00;
    localparam logic [7:0] CTCR_CNT_ONE = 8'h01;

    typedef enum logic [2:0] {
        CTCR_IDLE = 3'b001,
        CTCR_FG = 3'b010,
        CTCR_BG = 3'b100
    } ctcr_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } ctcr_req_t;

    typedef struct packed {
        logic test_pattern_enable;
        logic overrange_enable;
        logic timing_auto;
        logic calibration_active;
    } ctcr_ctl_t;
endpackage
`default_nettype wire

// >>> bench/ctcr_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ctcr_asserts
    import ctcr_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_B_IN,
    input wire ctcr_req_t REQ_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire ctcr_ctl_t CTL_OUT,
    input wire logic TIMING_CAL_PULSE_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RST_B_IN);
    wire logic [11:0] a = REQ_IN.addr;
    wire logic wt = REQ_IN.wr && a == CTCR_CFG0_ADDR && REQ_IN.wdata[3];
    property p_pat; REQ_IN.wr && a == CTCR_PAT_ADDR
        |=> CTL_OUT.test_pattern_enable == $past(REQ_IN.wdata[2]); endproperty
    a_pat: assert property (p_pat) else $error("pattern enable");
    property p_ovr; REQ_IN.wr && a == CTCR_PAT_ADDR
        |=> CTL_OUT.overrange_enable == $past(REQ_IN.wdata[1]); endproperty
    a_ovr: assert property (p_ovr) else $error("over-range enable");
    property p_tauto; REQ_IN.wr && a == CTCR_TCAL_ADDR
        |=> CTL_OUT.timing_auto == $past(REQ_IN.wdata[0]); endproperty
    a_tauto: assert property (p_tauto) else $error("timing auto");
    property p_pulse; wt && CTL_OUT.timing_auto |=> TIMING_CAL_PULSE_OUT; endproperty
    a_pulse: assert property (p_pulse) else $error("no timing pulse");
    property p_nopulse; TIMING_CAL_PULSE_OUT |-> $past(wt); endproperty
    a_nopulse: assert property (p_nopulse) else $error("stray timing pulse");
    property p_fg; wt |=> CTL_OUT.calibration_active [*8]; endproperty
    a_fg: assert property (p_fg) else $error("trigger did not start");
    property p_stat; REQ_IN.rd && a == CTCR_STAT_ADDR |=> RDATA_OUT[7:2] == 6'h02
        && RDATA_OUT[1] == !$past(CTL_OUT.calibration_active); endproperty
    a_stat: assert property (p_stat) else $error("status read");
    property p_tcal; REQ_IN.rd && a == CTCR_TCAL_ADDR
        |=> RDATA_OUT == {7'h01, $past(CTL_OUT.timing_auto)}; endproperty
    a_tcal: assert property (p_tcal) else $error("timing reg read");
    property p_rd0; !REQ_IN.rd |=> RDATA_OUT == 8'h00; endproperty
    a_rd0: assert property (p_rd0) else $error("read data not idle");
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import ctcr_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    ctcr_req_t req = '0;
    logic [7:0] rdata, d, r;
    ctcr_ctl_t ctl;
    logic pulse;
    logic [7:0] vec [16];
    int num_errors = 0;
    int n_compared = 0;
    int seed = 48;
    int i;
    always #2.5 clk = ~clk;
    ctcr_regs u_ctcr_regs(.MCLK_IN(clk), .RST_B_IN(rst_b), .REQ_IN(req),
        .RDATA_OUT(rdata), .CTL_OUT(ctl), .TIMING_CAL_PULSE_OUT(pulse));
    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task automatic wr(input logic [11:0] ad, input logic [7:0] wd);
        @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: wd};
        @(posedge clk) req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] ad, output logic [7:0] q);
        @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
        @(posedge clk) req.rd <= 1'b0;
        #1 q = rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] stat_exp(input logic stp, input logic dn);
        return CTCR_STAT_RSVD | {6'h00, stp, dn};
    endfunction
    task automatic conclude();
        $display("errors=%0d compared=%0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #50000 num_errors++;
        conclude();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(CTCR_VEC_ADDR, d); chk(d, CTCR_VEC_RST);
        rd(CTCR_TCAL_ADDR, d); chk(d, CTCR_TCAL_RST);
        rd(12'h123, d); chk(d, 8'h00);
        rd(CTCR_STAT_ADDR, d); chk(d, stat_exp(1'b1, 1'b0));
        for (i = 0; i < 8; i++) begin
            r = (i == 0) ? 8'hFF : 8'($random(seed));
            wr(CTCR_PAT_ADDR, r);
            #1 chk({7'h0, ctl.test_pattern_enable}, {7'h0, r[2]});
            chk({7'h0, ctl.overrange_enable}, {7'h0, r[1]});
            rd(CTCR_PAT_ADDR, d); chk(d, r & CTCR_PAT_MASK);
            wr(CTCR_TCAL_ADDR, r);
            rd(CTCR_TCAL_ADDR, d); chk(d, 8'h02 | (r & CTCR_TCAL_MASK));
        end
        wr(CTCR_CFG0_ADDR, 8'h10);
        for (i = 0; i < 16; i++) begin
            vec[i] = 8'($random(seed));
            wr(CTCR_VEC_ADDR, vec[i]);
        end
        wr(CTCR_CFG0_ADDR, 8'h00);
        rd(CTCR_VEC_ADDR, d); chk(d, vec[15]);
        wr(CTCR_VEC_ADDR, ~vec[0]);
        rd(CTCR_VEC_ADDR, d); chk(d, ~vec[0]);
        wr(CTCR_CFG0_ADDR, 8'h10);
        for (i = 0; i < 17; i++) begin
            rd(CTCR_VEC_ADDR, d); chk(d, vec[i % 16]);
        end
        wr(CTCR_TCAL_ADDR, 8'h01);
        wr(CTCR_CFG0_ADDR, 8'h08);
        #1 chk({7'h0, pulse}, 8'h01);
        rd(CTCR_STAT_ADDR, d); chk(d, stat_exp(1'b0, 1'b0));
        rd(CTCR_CFG0_ADDR, d); chk(d, 8'h00);
        for (i = 0; i < 200 && ctl.calibration_active !== 1'b0; i++) @(posedge clk);
        rd(CTCR_STAT_ADDR, d); chk(d, stat_exp(1'b1, 1'b1));
        wr(CTCR_BACK_ADDR, 8'h13);
        rd(CTCR_STAT_ADDR, d); chk(d, stat_exp(1'b0, 1'b1));
        wr(CTCR_BACK_ADDR, 8'h11);
        rd(CTCR_STAT_ADDR, d); chk(d, stat_exp(1'b0, 1'b1));
        for (i = 0; i < 40 && d[1] !== 1'b1; i++) rd(CTCR_STAT_ADDR, d);
        chk(d, stat_exp(1'b1, 1'b1));
        @(posedge clk) rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(CTCR_PAT_ADDR, d); chk(d, CTCR_PAT_RST);
        rd(CTCR_TCAL_ADDR, d); chk(d, CTCR_TCAL_RST);
        rd(CTCR_VEC_ADDR, d); chk(d, CTCR_VEC_RST);
        rd(CTCR_STAT_ADDR, d); chk(d, stat_exp(1'b1, 1'b0));
        wr(CTCR_CFG0_ADDR, 8'h08);
        #1 chk({7'h0, pulse}, 8'h00);
        rd(CTCR_STAT_ADDR, d); chk(d, stat_exp(1'b0, 1'b0));
        conclude();
    end
endmodule
bind ctcr_regs ctcr_asserts u_ctcr_asserts(.MCLK_IN, .RST_B_IN, .REQ_IN, .RDATA_OUT,
    .CTL_OUT, .TIMING_CAL_PULSE_OUT);
`default_nettype wire
